//--- pkg/ddrcd_pkg.sv
// Purpose: shared constants and types for the command decoder and its controller end
// Assumes: one clock, active-low asynchronous reset
// Notes: widths are defaults for the largest configuration
package ddrcd_pkg;
    // ==========================================
    // Widths
    localparam int BG_W = 2;
    localparam int BA_W = 2;
    localparam int ROW_W = 18;
    localparam int COL_W = 10;
    localparam int ADDR_W = 18;
    // ==========================================
    // Address pin positions
    localparam int A10_POS = 10;
    localparam int A12_POS = 12;
    localparam int A14_POS = 14;
    localparam int A15_POS = 15;
    localparam int A16_POS = 16;
    localparam int A17_POS = 17;
    // ==========================================
    // Command codes
    typedef enum logic [4:0] {
        DDRCD_CMD_NONE = 5'h00,
        DDRCD_CMD_MRS = 5'h01,
        DDRCD_CMD_REF = 5'h02,
        DDRCD_CMD_SRE = 5'h03,
        DDRCD_CMD_SRX = 5'h04,
        DDRCD_CMD_PRE = 5'h05,
        DDRCD_CMD_PREA = 5'h06,
        DDRCD_CMD_ACT = 5'h07,
        DDRCD_CMD_WR = 5'h08,
        DDRCD_CMD_WRA = 5'h09,
        DDRCD_CMD_RD = 5'h0a,
        DDRCD_CMD_RDA = 5'h0b,
        DDRCD_CMD_NOP = 5'h0c,
        DDRCD_CMD_DES = 5'h0d,
        DDRCD_CMD_PDE = 5'h0e,
        DDRCD_CMD_PDX = 5'h0f,
        DDRCD_CMD_ZQCL = 5'h10,
        DDRCD_CMD_ZQCS = 5'h11,
        DDRCD_CMD_RSVD = 5'h12
    } ddrcd_cmd_type;
    // ==========================================
    // Burst lengths
    localparam logic [3:0] BL8_BEATS = 4'h8;
    localparam logic [3:0] BC4_BEATS = 4'h4;
    localparam logic [1:0] BURST_CYC_BL8 = 2'h3;
    localparam logic [1:0] BURST_CYC_BC4 = 2'h1;
endpackage : ddrcd_pkg

//--- pkg/ddrcd_if.sv
// Purpose: command and address pins between controller and decoder
// Assumes: single clock domain
// Notes: all pins are one-way
`timescale 1ns/1ns
interface ddrcd_if;
    logic cke;
    logic cs_n;
    logic act_n;
    logic [ddrcd_pkg::ADDR_W-1:0] addr;
    logic [ddrcd_pkg::BG_W-1:0] bg;
    logic [ddrcd_pkg::BA_W-1:0] ba;
    logic odt;
    modport ctrl (output cke, output cs_n, output act_n, output addr, output bg, output ba, output odt);
    modport dev (input cke, input cs_n, input act_n, input addr, input bg, input ba, input odt);
endinterface : ddrcd_if

//--- design/ddrcd_decoder.sv
// Purpose: command decoder of the memory device end
// Assumes: pins arrive on clk from the controller logic
// Notes: outputs are registered on the same edge that samples the pins
`timescale 1ns/1ns
module ddrcd_decoder #(
    parameter int BG_W = ddrcd_pkg::BG_W,
    parameter int BA_W = ddrcd_pkg::BA_W,
    parameter int ROW_W = ddrcd_pkg::ROW_W,
    parameter int COL_W = ddrcd_pkg::COL_W
) (
    input wire logic clk,
    input wire logic reset_n,
    ddrcd_if.dev pins,
    input wire logic per_command_burst_select,
    output ddrcd_pkg::ddrcd_cmd_type cmd_r,
    output logic cmd_valid_r,
    output logic [BG_W-1:0] bg_r,
    output logic [BA_W-1:0] ba_r,
    output logic [ROW_W-1:0] row_r,
    output logic [COL_W-1:0] col_r,
    output logic [ddrcd_pkg::ADDR_W-1:0] opcode_r,
    output logic auto_pre_r,
    output logic [3:0] burst_len_r,
    output logic burst_busy_r,
    output logic self_refresh_r,
    output logic power_down_r,
    output logic odt_active_r,
    output logic refresh_pulse_r
);
    // ==========================================
    // Decode
    ddrcd_pkg::ddrcd_cmd_type cmd_nxt;
    logic cke_prev_r;
    logic ras_n, cas_n, we_n;
    logic busy_nxt;
    logic [1:0] burst_cnt_r;

    // Shared pins double as row bits when activating
    assign ras_n = pins.addr[ddrcd_pkg::A16_POS];
    assign cas_n = pins.addr[ddrcd_pkg::A15_POS];
    assign we_n = pins.addr[ddrcd_pkg::A14_POS];

    always_comb
    begin
        cmd_nxt = ddrcd_pkg::DDRCD_CMD_NONE;
        if (cke_prev_r && !pins.cke)
        begin
            // CKE falling: only refresh or deselect legal
            if (pins.cs_n)
                cmd_nxt = ddrcd_pkg::DDRCD_CMD_PDE;
            else if (pins.act_n && !ras_n && !cas_n && we_n)
                cmd_nxt = ddrcd_pkg::DDRCD_CMD_SRE;
        end
        else if (!cke_prev_r && pins.cke)
        begin
            // Exit sampled on clk: synchronous detection chosen
            if (pins.cs_n)
                cmd_nxt = self_refresh_r ? ddrcd_pkg::DDRCD_CMD_SRX
                                         : ddrcd_pkg::DDRCD_CMD_PDX;
        end
        else if (cke_prev_r && pins.cke)
        begin
            if (pins.cs_n)
                cmd_nxt = ddrcd_pkg::DDRCD_CMD_DES;
            else if (!pins.act_n)
                cmd_nxt = ddrcd_pkg::DDRCD_CMD_ACT;
            else
            begin
                // ODT never enters this decode
                unique case ({ras_n, cas_n, we_n})
                    3'h0: cmd_nxt = ddrcd_pkg::DDRCD_CMD_MRS;
                    3'h1: cmd_nxt = ddrcd_pkg::DDRCD_CMD_REF;
                    3'h2: cmd_nxt = pins.addr[ddrcd_pkg::A10_POS] ? ddrcd_pkg::DDRCD_CMD_PREA
                                                                  : ddrcd_pkg::DDRCD_CMD_PRE;
                    3'h3: cmd_nxt = ddrcd_pkg::DDRCD_CMD_RSVD;
                    3'h4: cmd_nxt = pins.addr[ddrcd_pkg::A10_POS] ? ddrcd_pkg::DDRCD_CMD_WRA
                                                                  : ddrcd_pkg::DDRCD_CMD_WR;
                    3'h5: cmd_nxt = pins.addr[ddrcd_pkg::A10_POS] ? ddrcd_pkg::DDRCD_CMD_RDA
                                                                  : ddrcd_pkg::DDRCD_CMD_RD;
                    3'h6: cmd_nxt = pins.addr[ddrcd_pkg::A10_POS] ? ddrcd_pkg::DDRCD_CMD_ZQCL
                                                                  : ddrcd_pkg::DDRCD_CMD_ZQCS;
                    3'h7: cmd_nxt = ddrcd_pkg::DDRCD_CMD_NOP;
                endcase
            end
        end
    end

    function automatic logic is_rw(input ddrcd_pkg::ddrcd_cmd_type c);
        is_rw = (c == ddrcd_pkg::DDRCD_CMD_WR) || (c == ddrcd_pkg::DDRCD_CMD_WRA) ||
                (c == ddrcd_pkg::DDRCD_CMD_RD) || (c == ddrcd_pkg::DDRCD_CMD_RDA);
    endfunction : is_rw

    // ==========================================
    // Registered command
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cke_prev_r <= 1'b0;
            cmd_r <= ddrcd_pkg::DDRCD_CMD_NONE;
            cmd_valid_r <= 1'b0;
        end
        else
        begin
            cke_prev_r <= pins.cke;
            cmd_r <= cmd_nxt;
            cmd_valid_r <= (cmd_nxt != ddrcd_pkg::DDRCD_CMD_NONE) && (cmd_nxt != ddrcd_pkg::DDRCD_CMD_DES);
        end
    end

    // Address fields only load on commands that use them; don't-cares leave them alone
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bg_r <= '0;
            ba_r <= '0;
            row_r <= '0;
            col_r <= '0;
            opcode_r <= '0;
            auto_pre_r <= 1'b0;
        end
        else
        begin
            if (cmd_nxt == ddrcd_pkg::DDRCD_CMD_ACT || cmd_nxt == ddrcd_pkg::DDRCD_CMD_PRE ||
                cmd_nxt == ddrcd_pkg::DDRCD_CMD_MRS || is_rw(cmd_nxt))
            begin
                bg_r <= pins.bg;
                ba_r <= pins.ba;
            end
            if (cmd_nxt == ddrcd_pkg::DDRCD_CMD_ACT)
                row_r <= pins.addr[ROW_W-1:0];
            if (is_rw(cmd_nxt))
            begin
                col_r <= pins.addr[COL_W-1:0];
                auto_pre_r <= pins.addr[ddrcd_pkg::A10_POS];
            end
            if (cmd_nxt == ddrcd_pkg::DDRCD_CMD_MRS)
                opcode_r <= pins.addr;
        end
    end

    // ==========================================
    // Burst tracking: no command can cut a burst short
    assign busy_nxt = is_rw(cmd_nxt) || (burst_busy_r && burst_cnt_r != 2'h0);
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            burst_busy_r <= 1'b0;
            burst_cnt_r <= 2'h0;
            burst_len_r <= ddrcd_pkg::BL8_BEATS;
        end
        else
        begin
            burst_busy_r <= busy_nxt;
            // A burst in its last cycle makes room for the next one
            if (is_rw(cmd_nxt) && (!burst_busy_r || burst_cnt_r == 2'h0))
            begin
                if (per_command_burst_select && !pins.addr[ddrcd_pkg::A12_POS])
                begin
                    burst_len_r <= ddrcd_pkg::BC4_BEATS;
                    burst_cnt_r <= ddrcd_pkg::BURST_CYC_BC4;
                end
                else
                begin
                    burst_len_r <= ddrcd_pkg::BL8_BEATS;
                    burst_cnt_r <= ddrcd_pkg::BURST_CYC_BL8;
                end
            end
            else if (burst_cnt_r != 2'h0)
                burst_cnt_r <= burst_cnt_r - 2'h1;
        end
    end

    // ==========================================
    // Power state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            self_refresh_r <= 1'b0;
            power_down_r <= 1'b0;
            odt_active_r <= 1'b0;
            refresh_pulse_r <= 1'b0;
        end
        else
        begin
            if (cmd_nxt == ddrcd_pkg::DDRCD_CMD_SRE)
                self_refresh_r <= 1'b1;
            else if (cmd_nxt == ddrcd_pkg::DDRCD_CMD_SRX)
                self_refresh_r <= 1'b0;
            if (cmd_nxt == ddrcd_pkg::DDRCD_CMD_PDE)
                power_down_r <= 1'b1;
            else if (cmd_nxt == ddrcd_pkg::DDRCD_CMD_PDX)
                power_down_r <= 1'b0;
            // Termination cut while self refresh is entered or held
            odt_active_r <= pins.odt && !self_refresh_r && cmd_nxt != ddrcd_pkg::DDRCD_CMD_SRE;
            // Refresh only issued while awake
            refresh_pulse_r <= cmd_nxt == ddrcd_pkg::DDRCD_CMD_REF && !power_down_r;
        end
    end
endmodule : ddrcd_decoder

//--- design/ddrcd_controller.sv
// Purpose: controller end that drives only legal command encodings
// Assumes: user requests one command at a time
// Notes: pins change on clk; decoder samples next edge
`timescale 1ns/1ns
module ddrcd_controller #(
    parameter int XS_CYCLES = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    ddrcd_if.ctrl pins,
    input wire logic req_valid,
    input ddrcd_pkg::ddrcd_cmd_type req_cmd,
    input wire logic [ddrcd_pkg::BG_W-1:0] req_bg,
    input wire logic [ddrcd_pkg::BA_W-1:0] req_ba,
    input wire logic [ddrcd_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_odt,
    input wire logic banks_idle,
    output logic req_ready_r
);
    // ==========================================
    // Pin drive
    logic cke_r, cs_n_r, act_n_r, odt_r, asleep_r;
    logic [ddrcd_pkg::ADDR_W-1:0] addr_r;
    logic [ddrcd_pkg::BG_W-1:0] bg_r;
    logic [ddrcd_pkg::BA_W-1:0] ba_r;
    logic [7:0] xs_cnt_r;
    logic ok;
    logic [2:0] cmd3;

    assign pins.cke = cke_r;
    assign pins.cs_n = cs_n_r;
    assign pins.act_n = act_n_r;
    assign pins.addr = addr_r;
    assign pins.bg = bg_r;
    assign pins.ba = ba_r;
    assign pins.odt = odt_r;

    // Reserved and no-op encodings are never driven; such requests leave a deselect on the pins
    always_comb
    begin
        ok = req_valid && req_ready_r;
        cmd3 = 3'h7;
        unique case (req_cmd)
            ddrcd_pkg::DDRCD_CMD_MRS: cmd3 = 3'h0;
            ddrcd_pkg::DDRCD_CMD_REF, ddrcd_pkg::DDRCD_CMD_SRE: cmd3 = 3'h1;
            ddrcd_pkg::DDRCD_CMD_PRE, ddrcd_pkg::DDRCD_CMD_PREA: cmd3 = 3'h2;
            ddrcd_pkg::DDRCD_CMD_WR, ddrcd_pkg::DDRCD_CMD_WRA: cmd3 = 3'h4;
            ddrcd_pkg::DDRCD_CMD_RD, ddrcd_pkg::DDRCD_CMD_RDA: cmd3 = 3'h5;
            ddrcd_pkg::DDRCD_CMD_ZQCL, ddrcd_pkg::DDRCD_CMD_ZQCS: cmd3 = 3'h6;
            default: cmd3 = 3'h7;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cke_r <= 1'b0;
            cs_n_r <= 1'b1;
            act_n_r <= 1'b1;
            addr_r <= '0;
            bg_r <= '0;
            ba_r <= '0;
            odt_r <= 1'b0;
            asleep_r <= 1'b0;
            xs_cnt_r <= 8'h0;
            req_ready_r <= 1'b0;
        end
        else
        begin
            // Default every cycle is a deselect, never a no-op
            cs_n_r <= 1'b1;
            act_n_r <= 1'b1;
            odt_r <= req_odt && !asleep_r;
            if (xs_cnt_r != 8'h0)
                xs_cnt_r <= xs_cnt_r - 8'h1;
            req_ready_r <= xs_cnt_r <= 8'h1 && !(ok && req_cmd == ddrcd_pkg::DDRCD_CMD_SRX);
            if (!asleep_r && !cke_r)
                cke_r <= 1'b1;
            else if (ok)
            begin
                bg_r <= req_bg;
                ba_r <= req_ba;
                addr_r <= req_addr;
                addr_r[ddrcd_pkg::A17_POS] <= 1'b0;
                unique case (req_cmd)
                    ddrcd_pkg::DDRCD_CMD_ACT:
                    begin
                        // Nothing but deselect while cke is low
                        if (!asleep_r)
                        begin
                            cs_n_r <= 1'b0;
                            act_n_r <= 1'b0;
                        end
                    end
                    ddrcd_pkg::DDRCD_CMD_SRE, ddrcd_pkg::DDRCD_CMD_PDE:
                    begin
                        // Self refresh only from all banks idle
                        if (!asleep_r && (req_cmd == ddrcd_pkg::DDRCD_CMD_PDE || banks_idle))
                        begin
                            cke_r <= 1'b0;
                            asleep_r <= 1'b1;
                            cs_n_r <= req_cmd == ddrcd_pkg::DDRCD_CMD_PDE;
                            addr_r[ddrcd_pkg::A16_POS] <= 1'b0;
                            addr_r[ddrcd_pkg::A15_POS] <= 1'b0;
                            addr_r[ddrcd_pkg::A14_POS] <= 1'b1;
                        end
                    end
                    ddrcd_pkg::DDRCD_CMD_SRX, ddrcd_pkg::DDRCD_CMD_PDX:
                    begin
                        // Synchronous exit with deselect
                        cke_r <= 1'b1;
                        asleep_r <= 1'b0;
                        if (req_cmd == ddrcd_pkg::DDRCD_CMD_SRX)
                            xs_cnt_r <= 8'(XS_CYCLES);
                    end
                    default:
                    begin
                        if (cmd3 != 3'h7 && !asleep_r)
                        begin
                            cs_n_r <= 1'b0;
                            addr_r[ddrcd_pkg::A16_POS] <= cmd3[2];
                            addr_r[ddrcd_pkg::A15_POS] <= cmd3[1];
                            addr_r[ddrcd_pkg::A14_POS] <= cmd3[0];
                            if (req_cmd == ddrcd_pkg::DDRCD_CMD_PREA || req_cmd == ddrcd_pkg::DDRCD_CMD_ZQCL ||
                                req_cmd == ddrcd_pkg::DDRCD_CMD_WRA || req_cmd == ddrcd_pkg::DDRCD_CMD_RDA)
                                addr_r[ddrcd_pkg::A10_POS] <= 1'b1;
                            else if (req_cmd != ddrcd_pkg::DDRCD_CMD_MRS)
                                addr_r[ddrcd_pkg::A10_POS] <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end
endmodule : ddrcd_controller

//--- testbench/ddrcd_asserts.sv
// Purpose: pin-level checks on the controller side of the link
// Assumes: one clock, reset_n active low
// Notes: helper flops track cke history and exit recovery
`timescale 1ns/1ns
module ddrcd_asserts #(
    parameter int XS_CYCLES = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic act_n,
    input wire logic [ddrcd_pkg::ADDR_W-1:0] addr,
    input wire logic [ddrcd_pkg::BG_W-1:0] bg,
    input wire logic [ddrcd_pkg::BA_W-1:0] ba,
    input wire logic odt
);
    // ==========================================
    // Helpers
    logic cke_prev_r;
    logic sr_r;
    logic [7:0] xs_cnt_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cke_prev_r <= 1'b0;
        else
            cke_prev_r <= cke;
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sr_r <= 1'b0;
        else if (cke_prev_r && !cke && !cs_n)
            sr_r <= 1'b1;
        else if (!cke_prev_r && cke)
            sr_r <= 1'b0;
    end
    // Counter instead of a repetition: XS_CYCLES is a parameter
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            xs_cnt_r <= 8'h00;
        else if (sr_r && !cke_prev_r && cke)
            xs_cnt_r <= 8'(XS_CYCLES);
        else if (xs_cnt_r != 8'h00)
            xs_cnt_r <= xs_cnt_r - 8'h01;
    end
    sequence s_sre;
        cke_prev_r && !cke && !cs_n;
    endsequence
    sequence s_exit;
        !cke_prev_r && cke;
    endsequence
    // ==========================================
    // Properties
    a_no_reserved_code: assert property (!cs_n && act_n |-> addr[16:14] != 3'h3)
        else $error("reserved encoding driven");
    a_no_nop_code: assert property (!cs_n && act_n |-> addr[16:14] != 3'h7)
        else $error("no-operation encoding driven");
    a_mrs_a17_low: assert property (!cs_n && act_n && addr[16:14] == 3'h0 |-> !addr[17])
        else $error("A17 high during mode set");
    a_exit_deselect: assert property (s_exit |-> cs_n)
        else $error("exit edge without deselect");
    a_sre_refresh_code: assert property (s_sre |-> act_n && addr[16:14] == 3'h1)
        else $error("cke fell with a non-refresh command");
    a_sleep_deselect: assert property (!cke && !cke_prev_r |-> cs_n)
        else $error("command while cke low");
    a_cmd_prev_cke: assert property (!cs_n |-> cke_prev_r)
        else $error("command without cke high before");
    a_xs_recovery: assert property (xs_cnt_r != 8'h00 |-> cs_n)
        else $error("command inside exit recovery");
endmodule : ddrcd_asserts

//--- testbench/testbench.sv
// Purpose: drives the controller user side, scores the decoder outputs
// Assumes: XS_CYCLES shortened to 2
// Notes: driver queues expectations, monitor pops them on cmd_valid_r
`timescale 1ns/1ns
module testbench;
    localparam int XS = 2;
    typedef struct {
        ddrcd_pkg::ddrcd_cmd_type c;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [17:0] a;
        logic [3:0] bl;
    } ddrcd_exp_type;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    ddrcd_pkg::ddrcd_cmd_type req_cmd = ddrcd_pkg::DDRCD_CMD_NONE;
    logic [1:0] req_bg = 2'h0;
    logic [1:0] req_ba = 2'h0;
    logic [17:0] req_addr = 18'h00000;
    logic req_odt = 1'b0;
    logic banks_idle = 1'b1;
    logic pcbs = 1'b0;
    logic req_ready_r, cmd_valid_r, auto_pre_r, burst_busy_r;
    logic self_refresh_r, power_down_r, odt_active_r, refresh_pulse_r;
    ddrcd_pkg::ddrcd_cmd_type cmd_r;
    logic [1:0] bg_r, ba_r;
    logic [17:0] row_r, opcode_r, a;
    logic [9:0] col_r;
    logic [3:0] burst_len_r;
    int error_cnt = 0;
    int tests_run = 0;
    int busy_cnt = 0;
    int exp_busy = 0;
    ddrcd_exp_type exp_q[$];
    ddrcd_exp_type m;
    ddrcd_pkg::ddrcd_cmd_type rw[4] = '{ddrcd_pkg::DDRCD_CMD_RD, ddrcd_pkg::DDRCD_CMD_RDA,
        ddrcd_pkg::DDRCD_CMD_WR, ddrcd_pkg::DDRCD_CMD_WRA};
    ddrcd_if ddrcd_if_inst();
    ddrcd_controller #(.XS_CYCLES(XS)) ddrcd_controller_inst (.clk(clk), .reset_n(reset_n),
        .pins(ddrcd_if_inst), .req_valid(req_valid), .req_cmd(req_cmd), .req_bg(req_bg),
        .req_ba(req_ba), .req_addr(req_addr), .req_odt(req_odt), .banks_idle(banks_idle),
        .req_ready_r(req_ready_r));
    ddrcd_decoder ddrcd_decoder_inst (.clk(clk), .reset_n(reset_n), .pins(ddrcd_if_inst),
        .per_command_burst_select(pcbs), .cmd_r(cmd_r), .cmd_valid_r(cmd_valid_r), .bg_r(bg_r),
        .ba_r(ba_r), .row_r(row_r), .col_r(col_r), .opcode_r(opcode_r), .auto_pre_r(auto_pre_r),
        .burst_len_r(burst_len_r), .burst_busy_r(burst_busy_r), .self_refresh_r(self_refresh_r),
        .power_down_r(power_down_r), .odt_active_r(odt_active_r), .refresh_pulse_r(refresh_pulse_r));
    ddrcd_asserts #(.XS_CYCLES(XS)) ddrcd_asserts_inst (.clk(clk), .reset_n(reset_n),
        .cke(ddrcd_if_inst.cke), .cs_n(ddrcd_if_inst.cs_n), .act_n(ddrcd_if_inst.act_n),
        .addr(ddrcd_if_inst.addr), .bg(ddrcd_if_inst.bg), .ba(ddrcd_if_inst.ba), .odt(ddrcd_if_inst.odt));
    always #5 clk = ~clk;
    // ==========================================
    // Tasks
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic end_sim();
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic idle(input int n);
        req_valid = 1'b0;
        repeat (n) @(negedge clk);
    endtask : idle
    // Entered at a falling edge; valid stays up so requests run back to back
    task automatic send(input ddrcd_pkg::ddrcd_cmd_type c, input logic [17:0] ad, input logic take);
        ddrcd_exp_type e;
        int n;
        n = 0;
        while (req_ready_r !== 1'b1 && n < 50)
        begin
            req_valid = 1'b0;
            n++;
            @(negedge clk);
        end
        if (n == 50)
        begin
            chk(1'b0, "ready timeout");
            end_sim();
        end
        e = '{c, 2'($urandom), 2'($urandom), ad, (pcbs && !ad[12]) ? 4'h4 : 4'h8};
        req_valid = 1'b1;
        req_cmd = c;
        req_bg = e.bg;
        req_ba = e.ba;
        req_addr = ad;
        if (take)
            exp_q.push_back(e);
        @(negedge clk);
    endtask : send
    task automatic wake();
        reset_n = 1'b1;
        exp_q.push_back('{ddrcd_pkg::DDRCD_CMD_PDX, 2'h0, 2'h0, 18'h00000, 4'h8});
    endtask : wake
    // ==========================================
    // Monitor
    always @(negedge clk)
    begin
        if (burst_busy_r === 1'b1)
            busy_cnt++;
        else if (busy_cnt != 0)
        begin
            chk(busy_cnt == exp_busy, "burst busy length");
            busy_cnt = 0;
        end
        if (reset_n && cmd_valid_r === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(1'b0, "unexpected command");
            else
            begin
                m = exp_q.pop_front();
                chk(cmd_r === m.c, "command code");
                case (m.c)
                    ddrcd_pkg::DDRCD_CMD_MRS: chk(bg_r === m.bg && ba_r === m.ba && opcode_r === {4'h0, m.a[13:0]}, "mode set");
                    ddrcd_pkg::DDRCD_CMD_ACT: chk(row_r === m.a && bg_r === m.bg && ba_r === m.ba, "activate row");
                    ddrcd_pkg::DDRCD_CMD_PRE: chk(bg_r === m.bg && ba_r === m.ba, "precharge bank");
                    ddrcd_pkg::DDRCD_CMD_REF: chk(refresh_pulse_r === 1'b1, "refresh pulse");
                    ddrcd_pkg::DDRCD_CMD_RD, ddrcd_pkg::DDRCD_CMD_RDA, ddrcd_pkg::DDRCD_CMD_WR, ddrcd_pkg::DDRCD_CMD_WRA:
                    begin
                        chk(col_r === m.a[9:0] && auto_pre_r === m.a[10] && burst_len_r === m.bl, "access");
                        exp_busy = (m.bl == 4'h8) ? 4 : 2;
                    end
                    default: ;
                endcase
            end
        end
    end
    // ==========================================
    // Main sequence
    initial
    begin
        void'($urandom(2));
        repeat (20) @(negedge clk);
        wake();
        for (int k = 0; k < 2; k++)
        begin
            pcbs = k[0];
            foreach (rw[i])
            begin
                a = 18'($urandom) & 18'h01bff;
                a[10] = (i % 2 == 1);
                send(rw[i], a, 1'b1);
                idle(6);
            end
        end
        send(ddrcd_pkg::DDRCD_CMD_MRS, {4'h8, 14'($urandom)}, 1'b1);
        send(ddrcd_pkg::DDRCD_CMD_ACT, {1'b0, 17'($urandom)}, 1'b1);
        send(ddrcd_pkg::DDRCD_CMD_PRE, 18'h00000, 1'b1);
        send(ddrcd_pkg::DDRCD_CMD_PREA, 18'h00400, 1'b1);
        send(ddrcd_pkg::DDRCD_CMD_REF, 18'h00000, 1'b1);
        send(ddrcd_pkg::DDRCD_CMD_ZQCL, 18'h00400, 1'b1);
        send(ddrcd_pkg::DDRCD_CMD_ZQCS, 18'h00000, 1'b1);
        send(ddrcd_pkg::DDRCD_CMD_RSVD, 18'h00000, 1'b0);
        send(ddrcd_pkg::DDRCD_CMD_NOP, 18'h00000, 1'b0);
        send(ddrcd_pkg::DDRCD_CMD_DES, 18'h00000, 1'b0);
        banks_idle = 1'b0;
        send(ddrcd_pkg::DDRCD_CMD_SRE, 18'h00000, 1'b0);
        idle(4);
        chk(self_refresh_r === 1'b0, "refused self refresh");
        banks_idle = 1'b1;
        req_odt = 1'b1;
        send(ddrcd_pkg::DDRCD_CMD_SRE, 18'h00000, 1'b1);
        idle(4);
        chk(self_refresh_r === 1'b1 && odt_active_r === 1'b0, "termination in self refresh");
        send(ddrcd_pkg::DDRCD_CMD_RD, 18'h00000, 1'b0);
        send(ddrcd_pkg::DDRCD_CMD_SRX, 18'h00000, 1'b1);
        idle(XS + 4);
        chk(self_refresh_r === 1'b0 && odt_active_r === 1'b1, "self refresh exit");
        send(ddrcd_pkg::DDRCD_CMD_PDE, 18'h00000, 1'b1);
        idle(4);
        chk(power_down_r === 1'b1, "power-down entry");
        send(ddrcd_pkg::DDRCD_CMD_REF, 18'h00000, 1'b0);
        send(ddrcd_pkg::DDRCD_CMD_PDX, 18'h00000, 1'b1);
        idle(4);
        chk(power_down_r === 1'b0, "power-down exit");
        send(ddrcd_pkg::DDRCD_CMD_SRE, 18'h00000, 1'b1);
        idle(3);
        #2 reset_n = 1'b0;
        #1 chk(self_refresh_r === 1'b0 && cmd_valid_r === 1'b0, "async reset");
        idle(3);
        wake();
        idle(10);
        chk(exp_q.size() == 0, "missing commands");
        end_sim();
    end
endmodule : testbench
